// File: hw/adccc_pkg.sv
package adccc_pkg;

	// ----------------------------------------------------------------
	// Register word addresses on the plain register port.
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS_CONTROL_ONE = 4'h0; // Channel, complete flag, enables.
	localparam logic [3:0] ADDR_STATUS_CONTROL_TWO = 4'h1; // Active, trigger, compare.
	localparam logic [3:0] ADDR_RESULT_HIGH = 4'h2; // Upper two result bits.
	localparam logic [3:0] ADDR_RESULT_LOW = 4'h3; // Lower eight result bits.
	localparam logic [3:0] ADDR_COMPARE_HIGH = 4'h4; // Upper two compare bits.
	localparam logic [3:0] ADDR_COMPARE_LOW = 4'h5; // Lower eight compare bits.
	localparam logic [3:0] ADDR_CONFIG = 4'h6; // Mode, clock source and divider.
	localparam logic [3:0] ADDR_PIN_DISABLE_GROUP0 = 4'h7; // Channels 0 to 7.
	localparam logic [3:0] ADDR_PIN_DISABLE_GROUP1 = 4'h8; // Channels 8 to 15.
	localparam logic [3:0] ADDR_PIN_DISABLE_GROUP2 = 4'h9; // Channels 16 to 23.

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int SC1_FLAG_BIT = 7; // Conversion complete flag.
	localparam int SC1_IRQ_BIT = 6; // Complete interrupt enable.
	localparam int SC1_CONT_BIT = 5; // Continuous conversion.
	localparam int SC2_TRIG_BIT = 6; // Hardware trigger enable.
	localparam int SC2_CMPEN_BIT = 5; // Compare enable.
	localparam int SC2_CMPGT_BIT = 4; // Compare for greater or equal.
	localparam int SC2_ACTIVE_BIT = 7; // Conversion in progress, read only.
	localparam logic [4:0] CHANNEL_OFF = 5'h1F; // All ones disables the converter.
	localparam logic [7:0] CONFIG_RESET = 8'h00; // Bus clock, divide by 1, 8-bit.
	localparam logic [7:0] PIN_DISABLE_RESET = 8'h00; // All pins digital.

	// ----------------------------------------------------------------
	// Encodings and conversion timing counts in converter clocks.
	// ----------------------------------------------------------------
	localparam logic [1:0] CLK_BUS = 2'h0; // Bus clock.
	localparam logic [1:0] CLK_BUS_HALF = 2'h1; // Bus clock halved.
	localparam logic [1:0] CLK_ALT = 2'h2; // Alternate clock.
	localparam logic [1:0] CLK_ASYNC = 2'h3; // Internal asynchronous clock.
	localparam logic [1:0] MODE_8BIT = 2'h0; // 8-bit conversion.
	localparam logic [1:0] MODE_10BIT = 2'h2; // 10-bit conversion.
	localparam logic [5:0] CONV_CYCLES_8 = 6'h11; // 17 converter clocks.
	localparam logic [5:0] CONV_CYCLES_10 = 6'h14; // 20 converter clocks.
	localparam logic [5:0] LONG_SAMPLE_EXTRA = 6'h14; // 20 more for long sample.

	// Configuration fields carried together.
	typedef struct packed {
		logic low_power; // Low-power converter configuration.
		logic [1:0] divide; // Divider select.
		logic long_sample; // Long sample time.
		logic [1:0] mode; // Conversion mode.
		logic [1:0] source; // Clock source select.
	} adccc_config_type;

	// Register port request.
	typedef struct packed {
		logic [3:0] addr; // Word address.
		logic [7:0] wdata; // Write data.
		logic wr; // Write strobe.
		logic rd; // Read strobe.
	} adccc_bus_type;

endpackage

// File: hw/adccc_top.sv
`timescale 1ns/1ps

// Functional notes
// - Disabled pin: output tristated, pullup off.
// - Disabled pin: input buffer off, reads zero.
// - Bit set disables channel pin digital control.
// - Second register maps channels 8 to 15.
// - Third register maps channels 16 to 23.
// - Disabled in reset or channel all ones.
// - Idle between conversions at lowest power.
// - Eleven or nine bit internal approximation.
// - Round to ten or eight, store results.
// - Set complete flag, interrupt when enabled.
// - Compare active when compare enable set.
// - Four clock sources, bus clock after reset.
// - Halved bus source allows divide by sixteen.
// - Async clock keeps running in low power.
// - Divider by 1, 2, 4 or 8.
// - Trigger rising edge starts conversion when enabled.
// - Trigger edge during conversion is ignored.
// - Continuous mode acts on first edge only.
// - Trigger works with every mode.
// - 10-bit or 8-bit, software or hardware start.
// - Source code 00 bus to 11 async.
// - Divider code 00 by 1 to 11 by 8.
// - Mode 00 eight bit, 10 ten bit.
// - Software start on control write, channel valid; the code also needs bit 7 of the written value clear.
module adccc_top
	import adccc_pkg::*;
#(
	parameter int PIN_COUNT = 16 // Channels with a real analog pin.
) (
	input wire logic sys_clk, // 250 MHz block clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire adccc_bus_type bus, // Register port request.
	output logic [7:0] rdata, // Read data, one cycle after the read strobe.
	input wire logic alternate_clock, // Alternate clock level, sampled.
	input wire logic converter_async_clock, // Internal async clock level, sampled.
	input wire logic hw_trigger_input, // Asynchronous hardware trigger.
	input wire logic [10:0] sar_value, // Approximation value from the analog core.
	input wire logic [23:0] port_pin_in, // Raw digital pin levels.
	output logic [23:0] port_read, // Pin levels as seen by port reads.
	output logic [23:0] pin_out_force_hiz, // Forces the pin output buffer off.
	output logic [23:0] pin_pullup_off, // Forces the pin pullup off.
	output logic converter_enable, // Analog core powered.
	output logic converter_clock, // Divided converter clock enable pulse.
	output logic async_clock_run, // Keeps the async clock generator alive.
	output logic conversion_irq // Complete interrupt request.
);

	// ----------------------------------------------------------------
	// Reset release through two flip-flops.
	// ----------------------------------------------------------------
	logic rst_meta, rst_n; // Synchroniser stages.

	// Assert at once, release after two edges.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	logic [4:0] channel_select; // Selected channel, all ones is off.
	logic conversion_complete_flag; // Set on a stored result.
	logic complete_irq_enable; // Interrupt enable.
	logic continuous; // Continuous conversion.
	logic hw_trigger_enable; // Hardware trigger select.
	logic compare_enable; // Automatic compare.
	logic compare_greater; // Compare for upper limit.
	logic [9:0] compare_value; // Compare value.
	adccc_config_type cfg; // Configuration register.
	logic [7:0] pin_dis [3]; // Pin-disable registers.
	logic [1:0] result_high; // Result upper bits.
	logic [7:0] result_low; // Result lower bits.
	logic active; // Conversion in progress.

	// Write decode.
	wire wr_sc1 = bus.wr && bus.addr == ADDR_STATUS_CONTROL_ONE;
	wire wr_sc2 = bus.wr && bus.addr == ADDR_STATUS_CONTROL_TWO;
	wire wr_cvh = bus.wr && bus.addr == ADDR_COMPARE_HIGH;
	wire wr_cvl = bus.wr && bus.addr == ADDR_COMPARE_LOW;
	wire wr_cfg = bus.wr && bus.addr == ADDR_CONFIG;
	wire mode_write = wr_sc2 || wr_cvh || wr_cvl || wr_cfg;
	wire rd_result_low = bus.rd && bus.addr == ADDR_RESULT_LOW;
	wire channel_valid = channel_select != CHANNEL_OFF;

	// Control, status and compare registers; the flag set wins a clear.
	logic store; // Result stored this cycle.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_select <= CHANNEL_OFF;
			complete_irq_enable <= 1'b0;
			continuous <= 1'b0;
			hw_trigger_enable <= 1'b0;
			compare_enable <= 1'b0;
			compare_greater <= 1'b0;
			compare_value <= 10'h000;
			cfg <= CONFIG_RESET;
			conversion_complete_flag <= 1'b0;
		end else begin
			if (wr_sc1) begin
				channel_select <= bus.wdata[4:0];
				complete_irq_enable <= bus.wdata[SC1_IRQ_BIT];
				continuous <= bus.wdata[SC1_CONT_BIT];
			end
			if (wr_sc2) begin
				hw_trigger_enable <= bus.wdata[SC2_TRIG_BIT];
				compare_enable <= bus.wdata[SC2_CMPEN_BIT];
				compare_greater <= bus.wdata[SC2_CMPGT_BIT];
			end
			if (wr_cvh) compare_value[9:8] <= bus.wdata[1:0];
			if (wr_cvl) compare_value[7:0] <= bus.wdata;
			if (wr_cfg) cfg <= bus.wdata;
			// A store sets the flag; control writes and low result reads clear it.
			if (store) conversion_complete_flag <= 1'b1;
			else if (wr_sc1 || mode_write || rd_result_low) conversion_complete_flag <= 1'b0;
		end
	end

	// Pin-disable registers, all eight bits stored in each group.
	for (genvar g = 0; g < 3; g++) begin : g_pin_regs
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) pin_dis[g] <= PIN_DISABLE_RESET;
			else if (bus.wr && bus.addr == ADDR_PIN_DISABLE_GROUP0 + 4'(g)) pin_dis[g] <= bus.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin control: bit n of group g is channel 8g+n.
	// ----------------------------------------------------------------
	for (genvar c = 0; c < 24; c++) begin : g_pins
		// Only channels with a real pin act on it.
		wire dis = (c < PIN_COUNT) && pin_dis[c / 8][c % 8];
		assign pin_out_force_hiz[c] = dis;
		assign pin_pullup_off[c] = dis;
		assign port_read[c] = port_pin_in[c] & ~dis;
	end

	// ----------------------------------------------------------------
	// Clock source selection and division.
	// ----------------------------------------------------------------
	logic half_tick; // Toggles for the halved bus source.
	logic alt_q, async_q, src_q; // Sampled source levels.
	logic [2:0] div_cnt; // Divider counter.

	// Source edge as a one-cycle enable; bus sources give pulses directly.
	wire alt_rise = alternate_clock && !alt_q;
	wire async_rise = converter_async_clock && !async_q;
	wire src_tick = (cfg.source == CLK_BUS) ? 1'b1 :
		(cfg.source == CLK_BUS_HALF) ? half_tick :
		(cfg.source == CLK_ALT) ? alt_rise : async_rise;
	wire [2:0] div_last = 3'((4'h1 << cfg.divide) - 4'h1);
	wire clk_en = src_tick && div_cnt == div_last;

	// Sample sources, run the halver and divider.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_tick <= 1'b0;
			alt_q <= 1'b0;
			async_q <= 1'b0;
			div_cnt <= 3'h0;
			converter_clock <= 1'b0;
		end else begin
			half_tick <= !half_tick;
			alt_q <= alternate_clock;
			async_q <= converter_async_clock;
			// A new divide setting restarts the count, so it never sits past the end value.
			if (wr_cfg) div_cnt <= 3'h0;
			else if (src_tick) div_cnt <= clk_en ? 3'h0 : div_cnt + 3'h1;
			converter_clock <= clk_en && active;
		end
	end

	// Async generator stays on while selected and converting, in any power mode.
	assign async_clock_run = cfg.source == CLK_ASYNC && active;
	assign converter_enable = active && channel_valid;

	// ----------------------------------------------------------------
	// Hardware trigger synchroniser and edge detect.
	// ----------------------------------------------------------------
	logic trig_meta, trig_sync, trig_prev; // Two stages and history.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			trig_meta <= hw_trigger_input;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
		end
	end
	wire trig_rise = trig_sync && !trig_prev;

	// ----------------------------------------------------------------
	// Conversion sequencer.
	// ----------------------------------------------------------------
	logic [5:0] conv_cnt; // Converter clocks left.
	wire is10 = cfg.mode == MODE_10BIT;
	wire [5:0] conv_len = (is10 ? CONV_CYCLES_10 : CONV_CYCLES_8)
		+ (cfg.long_sample ? LONG_SAMPLE_EXTRA : 6'h00);
	wire sw_start = wr_sc1 && !bus.wdata[SC1_FLAG_BIT] && !hw_trigger_enable
		&& bus.wdata[4:0] != CHANNEL_OFF;
	// Edges while busy are dropped, covering continuous runs after the first.
	wire hw_start = hw_trigger_enable && trig_rise && !active && channel_valid;
	wire finish = active && clk_en && conv_cnt == 6'h01;

	// Rounding: drop the extra bit with half added, saturating at full scale.
	wire [10:0] rnd10_sum = {1'b0, sar_value[10:1]} + {10'h000, sar_value[0]};
	wire [9:0] rnd10 = rnd10_sum[10] ? 10'h3FF : rnd10_sum[9:0];
	wire [8:0] rnd8_sum = {1'b0, sar_value[8:1]} + {8'h00, sar_value[0]};
	wire [7:0] rnd8 = rnd8_sum[8] ? 8'hFF : rnd8_sum[7:0];
	wire [9:0] rounded = is10 ? rnd10 : {2'b00, rnd8};
	wire [9:0] cmp_ref = is10 ? compare_value : {2'b00, compare_value[7:0]};
	wire [9:0] diff = rounded - cmp_ref;
	wire cmp_true = compare_greater ? (rounded >= cmp_ref) : (rounded < cmp_ref);
	assign store = finish && (!compare_enable || cmp_true);

	// Start, count, finish; mode writes abort.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			active <= 1'b0;
			conv_cnt <= 6'h00;
		end else if (sw_start || hw_start) begin
			active <= 1'b1;
			conv_cnt <= conv_len;
		end else if (mode_write || (wr_sc1 && !sw_start)) begin
			active <= 1'b0;
		end else if (finish) begin
			active <= continuous || (compare_enable && !cmp_true && continuous);
			conv_cnt <= conv_len;
		end else if (active && clk_en) begin
			conv_cnt <= conv_cnt - 6'h01;
		end
	end

	// Result registers; compare mode stores the difference.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_high <= 2'h0;
			result_low <= 8'h00;
		end else if (store) begin
			result_high <= is10 ? (compare_enable ? diff[9:8] : rounded[9:8]) : 2'h0;
			result_low <= compare_enable ? diff[7:0] : rounded[7:0];
		end
	end

	assign conversion_irq = conversion_complete_flag && complete_irq_enable;

	// ----------------------------------------------------------------
	// Read data, registered.
	// ----------------------------------------------------------------
	logic [7:0] read_mux;
	always_comb begin
		read_mux = 8'h00;
		unique case (bus.addr)
			ADDR_STATUS_CONTROL_ONE: read_mux = {conversion_complete_flag, complete_irq_enable,
				continuous, channel_select};
			ADDR_STATUS_CONTROL_TWO: read_mux = {active, hw_trigger_enable, compare_enable,
				compare_greater, 4'h0};
			ADDR_RESULT_HIGH: read_mux = {6'h00, result_high};
			ADDR_RESULT_LOW: read_mux = result_low;
			ADDR_COMPARE_HIGH: read_mux = {6'h00, compare_value[9:8]};
			ADDR_COMPARE_LOW: read_mux = compare_value[7:0];
			ADDR_CONFIG: read_mux = cfg;
			ADDR_PIN_DISABLE_GROUP0: read_mux = pin_dis[0];
			ADDR_PIN_DISABLE_GROUP1: read_mux = pin_dis[1];
			ADDR_PIN_DISABLE_GROUP2: read_mux = pin_dis[2];
			default: read_mux = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) rdata <= 8'h00;
		else rdata <= bus.rd ? read_mux : 8'h00;
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	a_pin_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pin_dis[0][0] |-> !port_read[0]) else $error("disabled pin reads nonzero");
	a_channel_off_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!channel_valid |-> !converter_enable) else $error("converter on with channel off");
	a_flag_after_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store |=> conversion_complete_flag) else $error("flag not set after store");
	a_busy_edge_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		active && trig_rise && !wr_sc1 && !mode_write && !finish
		|=> active && conv_cnt == $past(conv_cnt) - 6'($past(clk_en)))
		else $error("busy edge restarted conversion");
	a_trigger_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
		hw_start && !mode_write && !wr_sc1 |=> active && conv_cnt == $past(conv_len))
		else $error("trigger did not start");
	a_divider_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
		div_cnt <= div_last) else $error("divider count out of range");
	a_eight_bit_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
		store && !is10 |=> result_high == 2'h0) else $error("8-bit wrote high result");
	a_sync_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		trig_rise |-> $past(trig_meta) && !$past(trig_sync)) else $error("edge not synchronised");
	a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(conversion_irq) |-> $past(store)) else $error("interrupt without stored result");

endmodule // adccc_top

// File: sim/adccc_analog_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Analog core and clock sources seen from the control block.
// ----------------------------------------------------------------
module adccc_analog_model (
	input wire logic sys_clk, // Block clock.
	input wire logic converter_enable, // Analog core power from the block.
	input wire logic clock_run, // Async clock generator enable from the block.
	input wire logic [10:0] level, // Value the core settles to while powered.
	output logic [10:0] sar_value, // Approximation value.
	output logic alternate_clock, // Alternate clock level.
	output logic converter_async_clock // Async clock level.
);
	logic [10:0] last = 11'h000; // Last value shown while powered.
	logic [2:0] tick = 3'h0; // Six-cycle phase counter for the clock levels.

	// Unpowered, the core shows the inverse of its last value, never a stale copy.
	assign sar_value = converter_enable ? level : ~last;
	// Alternate clock rises every two cycles; the async clock every six, only while enabled.
	assign alternate_clock = tick[0];
	assign converter_async_clock = tick[1] && clock_run;

	// The phase counter runs freely; the powered value is remembered.
	always_ff @(posedge sys_clk) begin
		tick <= (tick == 3'h5) ? 3'h0 : tick + 3'h1;
		if (converter_enable) begin
			last <= level;
		end
	end
endmodule // adccc_analog_model

// File: sim/adc_conversion_control_tb.sv
`timescale 1ns/1ps

module adc_conversion_control_tb import adccc_pkg::*;;
	logic sys_clk = 1'b0; // Block clock.
	logic arst_n = 1'b0; // Reset, active low.
	adccc_bus_type bus = '0; // Register port request.
	logic [7:0] rdata; // Read data.
	logic hw_trigger_input = 1'b0; // Trigger level.
	logic [10:0] level = 11'h000; // Analog value for the model.
	logic [10:0] sar_value; // Model output.
	logic alternate_clock; // Model output.
	logic converter_async_clock; // Model output.
	logic [23:0] port_pin_in = 24'h000000; // Raw pin levels.
	logic [23:0] port_read, pin_out_force_hiz, pin_pullup_off; // Pin controls.
	logic converter_enable, converter_clock, async_clock_run, conversion_irq; // Status.
	int n_mismatch = 0; // Mismatches seen.
	int tests_run = 0; // Comparisons made.

	// Free-running 250 MHz clock.
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	adccc_analog_model u_model (.sys_clk(sys_clk), .converter_enable(converter_enable),
		.clock_run(async_clock_run),
		.level(level), .sar_value(sar_value), .alternate_clock(alternate_clock),
		.converter_async_clock(converter_async_clock));

	adccc_top #(.PIN_COUNT(16)) DUT (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus),
		.rdata(rdata), .alternate_clock(alternate_clock),
		.converter_async_clock(converter_async_clock), .hw_trigger_input(hw_trigger_input),
		.sar_value(sar_value), .port_pin_in(port_pin_in), .port_read(port_read),
		.pin_out_force_hiz(pin_out_force_hiz), .pin_pullup_off(pin_pullup_off),
		.converter_enable(converter_enable), .converter_clock(converter_clock),
		.async_clock_run(async_clock_run), .conversion_irq(conversion_irq));

	// ----------------------------------------------------------------
	// Shared tasks and expectation functions.
	// ----------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Compares one value and reports a difference at once.
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// A bound that ran out counts as a mismatch and ends the run.
	task automatic time_out(input string name);
		n_mismatch++;
		$display("mismatch %s expected done seen timeout", name);
		summarize();
	endtask

	// One-cycle register write.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask

	// One-cycle register read; data stands in the following cycle only.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
		// Return on an edge so that callers drive inputs on the rising edge.
		@(posedge sys_clk);
	endtask

	// Polls the in-progress bit until the converter is idle, bounded.
	task automatic wait_idle();
		logic [7:0] d;
		int i;
		d = 8'hFF;
		for (i = 0; i < 2000 && d[SC2_ACTIVE_BIT] !== 1'b0; i++) begin
			rd(ADDR_STATUS_CONTROL_TWO, d);
		end
		if (i == 2000) begin
			n_mismatch++;
			$display("mismatch idle wait expected 0 seen 1");
			summarize();
		end
	endtask

	// Rounded result for the mode, saturating at full scale.
	function automatic logic [9:0] rounded(input logic [10:0] v, input bit ten);
		if (ten) begin
			return (v[10:1] == 10'h3FF) ? 10'h3FF : v[10:1] + {9'h000, v[0]};
		end
		return (v[8:1] == 8'hFF) ? 10'h0FF : {2'h0, v[8:1] + {7'h00, v[0]}};
	endfunction

	// Waits for idle, then checks flag, interrupt, stored result and interrupt clear.
	task automatic finish_conv(input bit ten, input bit done, input logic [9:0] exp);
		logic [7:0] hi, lo, s1;
		wait_idle();
		chk("idle_power", 24'h0, {23'h0, converter_enable});
		rd(ADDR_STATUS_CONTROL_ONE, s1);
		chk("flag", {23'h0, done}, {23'h0, s1[SC1_FLAG_BIT]});
		chk("irq", {23'h0, done}, {23'h0, conversion_irq});
		if (done) begin
			rd(ADDR_RESULT_HIGH, hi);
			rd(ADDR_RESULT_LOW, lo);
			chk("result", {14'h0, exp}, {14'h0, (ten ? hi[1:0] : 2'h0), lo});
			chk("irq_clear", 24'h0, {23'h0, conversion_irq});
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d, g0, g1, g2;
		logic [9:0] r;
		logic [23:0] eff;
		adccc_config_type cfg;
		int n;
		void'($urandom(32'h893e658b));
		repeat (2) @(posedge sys_clk);
		chk("enable_in_reset", 24'h0, {23'h0, converter_enable});
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(ADDR_CONFIG, d);
		chk("config_reset", {16'h0, CONFIG_RESET}, {16'h0, d});
		rd(ADDR_STATUS_CONTROL_ONE, d);
		chk("channel_reset", 24'h00001F, {16'h0, d});
		for (int g = 0; g < 3; g++) begin
			rd(ADDR_PIN_DISABLE_GROUP0 + 4'(g), d);
			chk("pin_reset", {16'h0, PIN_DISABLE_RESET}, {16'h0, d});
		end
		// Random pin-disable patterns; the third group has no backed pins.
		repeat (4) begin
			g0 = 8'($urandom);
			g1 = 8'($urandom);
			g2 = 8'($urandom);
			port_pin_in <= 24'($urandom);
			wr(ADDR_PIN_DISABLE_GROUP0, g0);
			wr(ADDR_PIN_DISABLE_GROUP1, g1);
			wr(ADDR_PIN_DISABLE_GROUP2, g2);
			rd(ADDR_PIN_DISABLE_GROUP2, d);
			chk("group2_store", {16'h0, g2}, {16'h0, d});
			eff = {8'h00, g1, g0};
			chk("force_hiz", eff, pin_out_force_hiz);
			chk("pullup_off", eff, pin_pullup_off);
			chk("port_read", port_pin_in & ~eff, port_read);
		end
		// Every source and divider; software keeps the converter clock legal.
		for (int i = 0; i < 16; i++) begin
			level <= 11'($urandom);
			cfg = '{low_power: 1'($urandom), divide: 2'(i >> 2), long_sample: 1'($urandom),
				mode: ($urandom % 2) ? MODE_10BIT : MODE_8BIT, source: 2'(i)};
			wr(ADDR_CONFIG, cfg);
			wr(ADDR_STATUS_CONTROL_ONE, {2'b01, 1'b0, 5'($urandom % 16)});
			if (cfg.source == CLK_ASYNC) begin
				@(posedge sys_clk);
				chk("async_run", 24'h1, {23'h0, async_clock_run});
			end
			if (cfg.source < CLK_ALT) begin
				for (n = 0; n < 100 && converter_clock !== 1'b1; n++) @(posedge sys_clk) #1;
				if (n == 100) time_out("clock_first");
				n = 0;
				do begin
					@(posedge sys_clk) #1;
					n++;
				end while (converter_clock !== 1'b1 && n < 100);
				chk("clock_spacing", 24'((cfg.source == CLK_BUS_HALF ? 2 : 1) << cfg.divide), n);
				if (n == 100) time_out("clock_spacing");
			end
			finish_conv(cfg.mode == MODE_10BIT, 1'b1, rounded(level, cfg.mode == MODE_10BIT));
		end
		// Compare, 10-bit, greater-or-equal: met then not met.
		wr(ADDR_CONFIG, {3'h0, 1'b0, MODE_10BIT, CLK_BUS});
		level <= 11'($urandom) & 11'h3FF;
		@(posedge sys_clk);
		r = rounded(level, 1'b1);
		for (int k = 0; k < 2; k++) begin
			d = (k == 0) ? 8'($urandom % (r + 1)) : 8'h00;
			wr(ADDR_COMPARE_HIGH, (k == 0) ? 8'h00 : {6'h0, 2'((r + 1) >> 8)});
			wr(ADDR_COMPARE_LOW, (k == 0) ? d : 8'(r + 1));
			wr(ADDR_STATUS_CONTROL_TWO, 8'h30);
			wr(ADDR_STATUS_CONTROL_ONE, 8'h43);
			finish_conv(1'b1, k == 0, r - {2'h0, d});
		end
		// Hardware trigger: write does not start, edge does, second edge ignored.
		wr(ADDR_STATUS_CONTROL_TWO, 8'h40);
		wr(ADDR_STATUS_CONTROL_ONE, 8'h44);
		rd(ADDR_STATUS_CONTROL_TWO, d);
		chk("hw_no_sw_start", 24'h0, {23'h0, d[SC2_ACTIVE_BIT]});
		hw_trigger_input <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(ADDR_STATUS_CONTROL_TWO, d);
		chk("hw_start", 24'h1, {23'h0, d[SC2_ACTIVE_BIT]});
		hw_trigger_input <= 1'b0;
		repeat (3) @(posedge sys_clk);
		hw_trigger_input <= 1'b1;
		// A restart on this edge would still be busy here; the first run has ended.
		repeat (16) @(posedge sys_clk);
		rd(ADDR_STATUS_CONTROL_TWO, d);
		chk("hw_busy_edge", 24'h0, {23'h0, d[SC2_ACTIVE_BIT]});
		finish_conv(1'b1, 1'b1, rounded(level, 1'b1));
		repeat (6) @(posedge sys_clk);
		rd(ADDR_STATUS_CONTROL_TWO, d);
		chk("hw_ignored", 24'h0, {23'h0, d[SC2_ACTIVE_BIT]});
		// Continuous run keeps converting; an all-ones channel write stops it.
		wr(ADDR_STATUS_CONTROL_TWO, 8'h00);
		wr(ADDR_STATUS_CONTROL_ONE, 8'h25);
		repeat (60) @(posedge sys_clk);
		rd(ADDR_STATUS_CONTROL_TWO, d);
		chk("continuous_active", 24'h1, {23'h0, d[SC2_ACTIVE_BIT]});
		chk("continuous_power", 24'h1, {23'h0, converter_enable});
		rd(ADDR_STATUS_CONTROL_ONE, d);
		chk("continuous_flag", 24'h1, {23'h0, d[SC1_FLAG_BIT]});
		wr(ADDR_STATUS_CONTROL_ONE, {3'h0, CHANNEL_OFF});
		repeat (2) @(posedge sys_clk);
		chk("channel_off", 24'h0, {23'h0, converter_enable});
		// Reset in the middle of a continuous run clears everything.
		wr(ADDR_STATUS_CONTROL_ONE, 8'h25);
		repeat (30) @(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("enable_mid_reset", 24'h0, {23'h0, converter_enable});
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(ADDR_RESULT_LOW, d);
		chk("result_reset", 24'h0, {16'h0, d});
		rd(ADDR_STATUS_CONTROL_ONE, d);
		chk("channel_mid_reset", 24'h00001F, {16'h0, d});
		summarize();
	end
endmodule // adc_conversion_control_tb
